// File: include/fbp_defs.vh
`ifndef FBP_DEFS_VH
`define FBP_DEFS_VH

// Register byte offsets on the APB slave
`define FBP_OFF_ADDR 12'h000
`define FBP_OFF_CTRL 12'h008
`define FBP_OFF_RIS 12'h00C
`define FBP_OFF_IMASK 12'h010
`define FBP_OFF_MISC 12'h014
`define FBP_OFF_RDEN 12'h130
`define FBP_OFF_PGEN 12'h134
`define FBP_OFF_PORCTL 12'h200

// Control register fields
`define FBP_CTRL_WRITE 0
`define FBP_CTRL_ERASE 1
`define FBP_CTRL_COMMIT 3

// Interrupt bit positions
`define FBP_IRQ_ACCESS 0
`define FBP_IRQ_DONE 1

// Protection layout
`define FBP_NBLK 8
`define FBP_DBG_HI 31
`define FBP_DBG_LO 30
`define FBP_DBG_ON 2'h2
`define FBP_DBG_MASK 32'hC000_0000
`define FBP_RDEN_RST 32'h8000_00FF
`define FBP_PGEN_RST 32'h0000_00FF
`define FBP_DBG_COMMIT_ADDR 32'h0000_0900
`define FBP_BLK_LO 11
`define FBP_BLK_HI 13

// Timing: 1 us busy time per operation at 200 MHz
`define FBP_OP_NS 1000
`define FBP_CLK_NS 5
`define FBP_OP_CYC (`FBP_OP_NS / `FBP_CLK_NS)
`define FBP_CNT_W 8

`endif

// File: design/fbp_nv_store.v
`timescale 1ns/1ps
`include "fbp_defs.vh"

// Committed (non-volatile) copy of the protection sets; only reset by
// the factory-default reset value, never by power-on reset.
module fbp_nv_store (
    input wire pclk,
    input wire factory_rstn,
    input wire commit_pg,
    input wire commit_rd,
    input wire [31:0] pg_live,
    input wire [31:0] rd_live,
    output reg [31:0] pg_nv_q,
    output reg [31:0] rd_nv_q
);

    // Commit copies only cleared bits; a committed zero never returns
    always @(posedge pclk or negedge factory_rstn) begin
        if (!factory_rstn) begin
            pg_nv_q <= `FBP_PGEN_RST;
            rd_nv_q <= `FBP_RDEN_RST;
        end else begin
            if (commit_pg) begin
                pg_nv_q <= pg_nv_q & pg_live;
            end
            if (commit_rd) begin
                rd_nv_q <= rd_nv_q & rd_live;
            end
        end
    end

endmodule

// File: design/fbp_top.v
`timescale 1ns/1ps
`include "fbp_defs.vh"

// What this block does
// - Program-enable and read-enable sets, one bit per 2-KB block, 32-bit each.
// - Program-enable one allows program/erase; zero refuses any change.
// - Read-enable one allows data reads; zero allows instruction fetch only.
// - Both bits act independently, giving four protection combinations.
// - Data read of a read-protected block is refused with a bus fault.
// - Program/erase on protected block flags access violation; irq if masked in.
// - Factory state has all implemented block bits at one.
// - Software can only clear bits; commit makes clears permanent.
// - Power-on reset restores uncommitted bits to committed values.
// - Commit requested via control register saves the selected set.
// - Programming-done flag sets when program or erase finishes.
// - Raw flags always visible; masked = raw and mask; masked drives irq.
// - Writing one to masked-status-clear clears raw and masked flag.
// - Debug port access allowed only while debug field equals 0x2.
// - Committed cleared debug field never returns to factory value.
// - Committed debug disable takes effect only from next power-up.
// - Debug disable leaves scan test access port fully working.
// - Address 0x900 commits debug field with read-enable clears.
module fbp_top (
    input wire pclk,
    input wire presetn,
    input wire factory_rstn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [31:0] flash_addr,
    input wire flash_fetch,
    input wire flash_data_rd,
    output wire flash_read_fault,
    input wire jtag_swd_dap_req,
    output wire debug_access_port_en,
    output wire scan_tap_en,
    output wire flash_op_busy,
    output wire flash_op_start,
    output wire flash_irq
);

    // Sequencer states, one-hot
    localparam ST_IDLE = 3'b001;
    localparam ST_BUSY = 3'b010;
    localparam ST_DONE = 3'b100;

    // Software-visible and sequencer state
    reg [31:0] addr_q;
    reg [3:0] ctrl_q;
    reg [1:0] ris_q;
    reg [1:0] ris_d;
    reg [1:0] imask_q;
    reg [31:0] pg_q;
    reg [31:0] rd_q;
    reg [1:0] dbg_lat_q;
    reg por_load_q;
    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [`FBP_CNT_W-1:0] cnt_q;
    reg is_commit_q;
    reg [1:0] dap_sync_q;
    wire [31:0] pg_nv;
    wire [31:0] rd_nv;
    wire wr_acc;
    wire rd_acc;
    wire op_req;
    wire op_start;
    wire commit_req;
    wire viol;
    wire [2:0] tgt_blk;
    wire [2:0] rd_blk;
    wire commit_pg;
    wire commit_rd;
    wire [31:0] blk_mask;
    wire [1:0] mis;
    wire done_evt;
    wire [`FBP_NBLK-1:0] blk_prog_ok;
    wire [`FBP_NBLK-1:0] blk_read_ok;

    // Single-cycle APB slave, never stalls
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;

    // Only implemented blocks carry protection bits
    assign blk_mask = {{(32 - `FBP_NBLK){1'b0}}, {`FBP_NBLK{1'b1}}};

    // Per-block policy bits; each pair is decoded on its own
    genvar gi;
    generate
        for (gi = 0; gi < `FBP_NBLK; gi = gi + 1) begin : g_blk
            assign blk_prog_ok[gi] = pg_q[gi];
            assign blk_read_ok[gi] = rd_q[gi];
        end
    endgenerate

    // Target block of a program/erase, from flash address register
    assign tgt_blk = addr_q[`FBP_BLK_HI:`FBP_BLK_LO];
    assign op_req = wr_acc && (paddr == `FBP_OFF_CTRL) && (st_q == ST_IDLE);
    assign commit_req = op_req & pwdata[`FBP_CTRL_COMMIT];

    // Program/erase blocked by a cleared program-enable bit
    assign viol = op_req & ~pwdata[`FBP_CTRL_COMMIT]
                  & (pwdata[`FBP_CTRL_WRITE] | pwdata[`FBP_CTRL_ERASE])
                  & ~blk_prog_ok[tgt_blk];
    assign op_start = op_req & ~pwdata[`FBP_CTRL_COMMIT]
                      & (pwdata[`FBP_CTRL_WRITE] | pwdata[`FBP_CTRL_ERASE])
                      & blk_prog_ok[tgt_blk];
    assign flash_op_start = op_start;
    assign flash_op_busy = (st_q == ST_BUSY);

    // Commit target selection; 0x900 also takes the read set
    assign commit_pg = (st_q == ST_DONE) && is_commit_q
                       && (addr_q != `FBP_DBG_COMMIT_ADDR) && addr_q[0];
    assign commit_rd = (st_q == ST_DONE) && is_commit_q
                       && ((addr_q == `FBP_DBG_COMMIT_ADDR) || !addr_q[0]);

    // Committed copy sits outside the power-on reset so clears survive it
    fbp_nv_store u_nv (
        .pclk(pclk),
        .factory_rstn(factory_rstn),
        .commit_pg(commit_pg),
        .commit_rd(commit_rd),
        .pg_live(pg_q),
        .rd_live(rd_q),
        .pg_nv_q(pg_nv),
        .rd_nv_q(rd_nv)
    );

    // Operation sequencer: fixed busy time for commit and program/erase
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (op_start | commit_req) begin
                    st_d = ST_BUSY;
                end
            end
            ST_BUSY: begin
                if (cnt_q == `FBP_OP_CYC - 1) begin
                    st_d = ST_DONE;
                end
            end
            ST_DONE: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // State, busy counter and commit marker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= ST_IDLE;
            cnt_q <= {`FBP_CNT_W{1'b0}};
            is_commit_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == ST_BUSY) begin
                cnt_q <= cnt_q + 1'b1;
            end else begin
                cnt_q <= {`FBP_CNT_W{1'b0}};
            end
            if (st_q == ST_IDLE) begin
                is_commit_q <= commit_req;
            end
        end
    end

    assign done_evt = (st_q == ST_DONE) && !is_commit_q;

    // Control register: bits stay set while busy, clear on completion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 4'h0;
        end else if (op_start | commit_req) begin
            ctrl_q <= pwdata[3:0];
        end else if (st_q == ST_DONE) begin
            ctrl_q <= 4'h0;
        end
    end

    // Address and mask registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_q <= 32'h0000_0000;
            imask_q <= 2'h0;
        end else begin
            if (wr_acc && paddr == `FBP_OFF_ADDR && st_q == ST_IDLE) begin
                addr_q <= pwdata;
            end
            if (wr_acc && paddr == `FBP_OFF_IMASK) begin
                imask_q <= pwdata[1:0];
            end
        end
    end

    // Raw flags: a new event wins over a same-cycle clear
    always @* begin
        ris_d = ris_q;
        if (wr_acc && paddr == `FBP_OFF_MISC) begin
            ris_d = ris_q & ~pwdata[1:0];
        end
        if (viol) begin
            ris_d[`FBP_IRQ_ACCESS] = 1'b1;
        end
        if (done_evt) begin
            ris_d[`FBP_IRQ_DONE] = 1'b1;
        end
    end

    // Raw flag storage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ris_q <= 2'h0;
        end else begin
            ris_q <= ris_d;
        end
    end

    assign mis = ris_q & imask_q;
    assign flash_irq = |mis;

    // Live protection sets: reload from committed copy after power-on
    // reset, since reset can only load constants
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_load_q <= 1'b1;
            pg_q <= `FBP_PGEN_RST;
            rd_q <= `FBP_RDEN_RST;
        end else if (por_load_q) begin
            por_load_q <= 1'b0;
            pg_q <= pg_nv;
            rd_q <= rd_nv;
        end else if (wr_acc && paddr == `FBP_OFF_PGEN) begin
            pg_q <= pg_q & pwdata & blk_mask;
        end else if (wr_acc && paddr == `FBP_OFF_RDEN) begin
            rd_q <= rd_q & pwdata & (blk_mask | `FBP_DBG_MASK);
        end
    end

    // Debug field latched once per power-up from committed value
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_lat_q <= 2'h0;
        end else if (por_load_q) begin
            dbg_lat_q <= rd_nv[`FBP_DBG_HI:`FBP_DBG_LO];
        end
    end

    // Debug request pin crosses into pclk domain
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dap_sync_q <= 2'h0;
        end else begin
            dap_sync_q <= {dap_sync_q[0], jtag_swd_dap_req};
        end
    end

    assign debug_access_port_en = dap_sync_q[1]
                                  & (dbg_lat_q == `FBP_DBG_ON) & ~por_load_q;
    assign scan_tap_en = 1'b1;

    // Data read fault; instruction fetch always allowed
    assign rd_blk = flash_addr[`FBP_BLK_HI:`FBP_BLK_LO];
    assign flash_read_fault = flash_data_rd & ~flash_fetch & ~blk_read_ok[rd_blk];

    // Read mux, registered at the setup edge so it stands in the access phase
    // Limitation: the value is one cycle old by the access edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `FBP_OFF_ADDR: prdata <= addr_q;
                `FBP_OFF_CTRL: prdata <= {28'h000_0000, ctrl_q};
                `FBP_OFF_RIS: prdata <= {30'h0000_0000, ris_q};
                `FBP_OFF_IMASK: prdata <= {30'h0000_0000, imask_q};
                `FBP_OFF_MISC: prdata <= {30'h0000_0000, mis};
                `FBP_OFF_RDEN: prdata <= rd_q;
                `FBP_OFF_PGEN: prdata <= pg_q;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// File: bench/fbp_top_asserts.sv
`timescale 1ns/1ps
// Port-level watch on the protection block
module fbp_top_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire flash_fetch,
    input wire flash_data_rd,
    input wire flash_read_fault,
    input wire jtag_swd_dap_req,
    input wire debug_access_port_en,
    input wire scan_tap_en,
    input wire flash_op_busy,
    input wire flash_op_start
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // An operation occupies the flash for a while, then frees it
    sequence busy_run;
        flash_op_busy [*8];
    endsequence
    sequence busy_end;
        !flash_op_busy;
    endsequence
    a_op_runs: assert property (
        flash_op_start |=> busy_run ##[1:200] busy_end) else $error("op length");
    a_busy_no_start: assert property (
        flash_op_busy && $past(flash_op_busy) |-> !flash_op_start) else $error("start in op");
    a_fetch_no_fault: assert property (
        flash_fetch && !flash_data_rd |-> !flash_read_fault) else $error("fetch fault");
    a_fault_data_only: assert property (
        flash_read_fault |-> flash_data_rd) else $error("stray fault");
    a_scan_kept: assert property (
        scan_tap_en) else $error("scan port off");
    a_dap_sync: assert property (
        debug_access_port_en |-> $past(jtag_swd_dap_req, 2)) else $error("debug no req");
    a_dap_steady: assert property (
        $past(jtag_swd_dap_req, 2) && $past(debug_access_port_en) |-> debug_access_port_en)
        else $error("debug lost");
    a_apb_no_wait: assert property (
        psel && penable |-> pready && !pslverr) else $error("bus stall");
endmodule

bind fbp_top fbp_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .flash_fetch, .flash_data_rd, .flash_read_fault, .jtag_swd_dap_req,
    .debug_access_port_en, .scan_tap_en, .flash_op_busy, .flash_op_start);

// File: bench/fbp_host_model.sv
`timescale 1ns/1ps
// Far-side master; address toggles while idle so stale values never look valid
module fbp_host_model (
    input wire pclk,
    input wire [2:0] blk,
    input wire want_fetch,
    input wire want_data,
    output reg [31:0] flash_addr = 32'h0000_0000,
    output reg flash_fetch = 1'b0,
    output reg flash_data_rd = 1'b0
);
    // Fetch or data read of one word in the chosen 2-KB block
    always @(posedge pclk) begin
        flash_fetch <= want_fetch;
        flash_data_rd <= want_data;
        if (want_fetch || want_data) begin
            flash_addr <= {18'h0, blk, 11'h004};
        end else begin
            flash_addr <= ~flash_addr;
        end
    end
endmodule

// File: bench/tb_flash_block_protection.sv
`timescale 1ns/1ps
`include "fbp_defs.vh"
module tb_flash_block_protection;
    logic pclk, presetn, factory_rstn, psel, penable, pwrite, dreq, pready, pslverr;
    logic fault, debug_access_port, scan, busy, start, irq, ff, fd, wf, wd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, fa;
    logic [2:0] blk;
    int mismatches, n_compared;
    fbp_top dut (.pclk, .presetn, .factory_rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .flash_addr(fa), .flash_fetch(ff), .flash_data_rd(fd),
        .flash_read_fault(fault), .jtag_swd_dap_req(dreq), .debug_access_port_en(debug_access_port),
        .scan_tap_en(scan), .flash_op_busy(busy), .flash_op_start(start), .flash_irq(irq));
    fbp_host_model host (.pclk, .blk, .want_fetch(wf), .want_data(wd), .flash_addr(fa),
        .flash_fetch(ff), .flash_data_rd(fd));
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task conclude;
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer; read data is taken at the edge where pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            mismatches++;
            conclude();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // Poll control until the operation bits clear
    task idle;
        int k;
        k = 0;
        rd = 32'h0000_0001;
        while (rd !== 32'h0000_0000 && k < 400) begin
            apb(1'b0, `FBP_OFF_CTRL, 32'h0000_0000);
            k++;
        end
        if (rd !== 32'h0000_0000) begin
            mismatches++;
            conclude();
        end
    endtask
    // Power cycle: committed copy survives, live copy reloads
    task por;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task acc(input logic [2:0] b, input logic data, input logic e);
        @(posedge pclk);
        blk <= b;
        wd <= data;
        wf <= !data;
        repeat (2) @(posedge pclk);
        chk(fault, e);
        wd <= 1'b0;
        wf <= 1'b0;
    endtask
    initial begin
        {presetn, factory_rstn, psel, penable, pwrite, wf, wd} = '0;
        {paddr, pwdata, blk} = '0;
        dreq = 1'b1;
        mismatches = 0;
        n_compared = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        factory_rstn <= 1'b1;
        repeat (2) @(posedge pclk);
        rdc(`FBP_OFF_RDEN, 32'h8000_00FF);
        rdc(`FBP_OFF_PGEN, 32'h0000_00FF);
        rdc(12'h0FC, 32'h0000_0000);
        chk(debug_access_port, 1'b1);
        // Debug request passes the two-flop synchroniser both ways
        dreq <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(debug_access_port, 1'b0);
        dreq <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(debug_access_port, 1'b1);
        // Bits only clear; block 0 then refuses a program
        wr(`FBP_OFF_PGEN, 32'h0000_00FE);
        wr(`FBP_OFF_PGEN, 32'hFFFF_FFFF);
        rdc(`FBP_OFF_PGEN, 32'h0000_00FE);
        wr(`FBP_OFF_IMASK, 32'h0000_0001);
        wr(`FBP_OFF_ADDR, 32'h0000_0000);
        wr(`FBP_OFF_CTRL, 32'h0000_0001);
        rdc(`FBP_OFF_RIS, 32'h0000_0001);
        chk(busy, 1'b0);
        rdc(`FBP_OFF_MISC, 32'h0000_0001);
        chk(irq, 1'b1);
        wr(`FBP_OFF_MISC, 32'h0000_0001);
        rdc(`FBP_OFF_RIS, 32'h0000_0000);
        chk(irq, 1'b0);
        // Erase of open block 1; done flag is raw only with its mask off
        wr(`FBP_OFF_ADDR, 32'h0000_0800);
        wr(`FBP_OFF_CTRL, 32'h0000_0002);
        rdc(`FBP_OFF_CTRL, 32'h0000_0002);
        chk(busy, 1'b1);
        idle();
        rdc(`FBP_OFF_RIS, 32'h0000_0002);
        rdc(`FBP_OFF_MISC, 32'h0000_0000);
        chk(irq, 1'b0);
        wr(`FBP_OFF_MISC, 32'h0000_0000);
        rdc(`FBP_OFF_RIS, 32'h0000_0002);
        wr(`FBP_OFF_MISC, 32'h0000_0002);
        rdc(`FBP_OFF_RIS, 32'h0000_0000);
        // Commit program set; read-protect block 2 but leave it uncommitted
        wr(`FBP_OFF_ADDR, 32'h0000_0001);
        wr(`FBP_OFF_CTRL, 32'h0000_0008);
        rdc(`FBP_OFF_CTRL, 32'h0000_0008);
        idle();
        rdc(`FBP_OFF_RIS, 32'h0000_0000);
        wr(`FBP_OFF_RDEN, 32'hFFFF_FFFB);
        acc(3'd2, 1'b1, 1'b1);
        acc(3'd2, 1'b0, 1'b0);
        acc(3'd3, 1'b1, 1'b0);
        por();
        rdc(`FBP_OFF_PGEN, 32'h0000_00FE);
        rdc(`FBP_OFF_RDEN, 32'h8000_00FF);
        acc(3'd2, 1'b1, 1'b0);
        // Debug field cleared and committed; effect waits for power-up
        wr(`FBP_OFF_RDEN, 32'h3FFF_FFF7);
        wr(`FBP_OFF_ADDR, `FBP_DBG_COMMIT_ADDR);
        wr(`FBP_OFF_CTRL, 32'h0000_0008);
        idle();
        chk(debug_access_port, 1'b1);
        por();
        chk(debug_access_port, 1'b0);
        acc(3'd3, 1'b1, 1'b1);
        wr(`FBP_OFF_RDEN, 32'hFFFF_FFFF);
        rdc(`FBP_OFF_RDEN, 32'h0000_00F7);
        chk(scan, 1'b1);
        conclude();
    end
endmodule
